// *** hdl/chan_post_regs.vh ***
/*
 * Register offsets, field positions, reset values and timing counts for the
 * channel post-processing block. Assumes a 40 MHz system clock.
 */
`ifndef CHAN_POST_REGS_VH
`define CHAN_POST_REGS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define IF_FORMAT_CONFIG_ADDR   7'h12
`define POWER_CTRL_ADDR         7'h13
`define DELAY_CONFIG_ADDR       7'h14
`define CORR_ENABLE_ADDR        7'h15
`define OFFSET_BASE_ADDR        7'h20
`define GAIN_BASE_ADDR          7'h30

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define FMT_LSB                 0
`define AVG_SEL_LSB             2
`define FMT_AVERAGE             2'h3
`define AVG_SEL_FOUR            2'h0
`define PWR_MODE_BIT            0
`define SLEEP_EN_BIT            1
`define ANTIALIAS_MODE_BIT_BIT             2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IF_FORMAT_RESET         8'h00
`define POWER_CTRL_RESET        8'h00
`define DELAY_CONFIG_RESET      8'h00
`define CORR_ENABLE_RESET       8'h00

// ----------------------------------------------------------------
// Power modes
// ----------------------------------------------------------------
`define PMODE_LOW_POWER         2'h0
`define PMODE_HIGH_PERF         2'h1
`define PMODE_SLEEP             2'h2
`define PMODE_POWER_DOWN        2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS           25
`define PWR_HOLD_MS             10
`define PWR_HOLD_CYCLES         ((`PWR_HOLD_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// *** hdl/sample_fifo.v ***
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock, synchronous active-low reset and a clock enable.
 */
`timescale 1ns/10ps
module sample_fifo #(
    parameter WIDTH = 96,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_n,
    input  wire             ce,
    // Fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output wire             out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @* begin
        out_data = mem[rd_ptr];
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else if (ce) begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr      <= wr_ptr + 1'b1;
            end
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule // sample_fifo

// *** hdl/chan_postprocess.v ***
/*
 * Per-channel post-processing and power/antialias mode control of a
 * four-channel converter: delay, offset/gain correction, averaging.
 * Assumes filter samples arrive synchronous to CLK_SYS with a valid strobe,
 * and a simple register write/read port from the serial-port logic.
 */
// Function
// - Each channel delayed by 0, 1 or 2 valid samples per its delay field.
// - Power select 0 gives low power, 1 high performance, sleep off.
// - Register mode: sleep enable 1 forces sleep unless the power-down pin is low; never in pin mode.
// - Power-down pin honoured in both control modes.
// - Antialias mode one after reset.
// - Antialias mode two only in register mode with bit set.
// - Averaging applied after the filter on channel results.
// - Four-to-one averaging gives one averaged channel.
// - Two-to-one averaging gives two averaged channels from pairs.
// - Pin mode offers only four-to-one averaging, straps both high.
// - Register mode: format bits 1:0 equal 11 enable averaging.
// - Averaging option taken from format bits 3:2.
// - Offset and gain correction only in register mode.
// - Reset restores factory gain and offset coefficients.
// - 23-bit signed offset applied only when its enable is set.
// - One offset code shifts output by two codes.
// - 20-bit gain, plus or minus half, applied when selected.
// - Pin four-to-one result on first data line only.
`timescale 1ns/10ps
`include "chan_post_regs.vh"
module chan_postprocess #(
    parameter DW          = 24,
    parameter FIFO_DEPTH  = 32,
    parameter HOLD_CYCLES = `PWR_HOLD_CYCLES,
    parameter [91:0] FACTORY_OFFSET = 92'h0,
    parameter [79:0] FACTORY_GAIN   = 80'h0
) (
    // Clock, reset, enable
    input  wire            CLK_SYS,
    input  wire            RST_N,
    input  wire            CE,
    // Straps and pins
    input  wire            PIN_CONTROL,
    input  wire            POWER_MODE_STRAP_PIN,
    input  wire            OUTPUT_FORMAT_STRAP_LOW,
    input  wire            OUTPUT_FORMAT_STRAP_HIGH,
    input  wire            POWER_DOWN_N,
    // Register port
    input  wire            REG_WR,
    input  wire [6:0]      REG_ADDR,
    input  wire [23:0]     REG_WDATA,
    output reg  [23:0]     REG_RDATA,
    // Filter samples in
    input  wire            SAMPLE_VALID,
    input  wire [4*DW-1:0] SAMPLE_DATA,
    // Processed samples out
    output wire            OUT_VALID,
    input  wire            OUT_READY,
    output wire [4*DW-1:0] OUT_DATA,
    output reg  [3:0]      LINE_ENABLE,
    output wire            OVERRUN,
    // Mode status
    output reg  [1:0]      POWER_MODE,
    output reg             ANTIALIAS_MODE_TWO,
    output reg             LOW_POWER_READY
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [7:0]  interface_format_config;
    reg  [7:0]  power_ctrl;
    reg  [7:0]  multiphase_delay_config;
    reg  [7:0]  corr_enable;
    reg  [22:0] channel_offset_coefficient [0:3];
    reg  [19:0] channel_gain_coefficient   [0:3];
    reg  [4*DW-1:0] dly1;
    reg  [4*DW-1:0] dly2;
    reg  [31:0] hold_cnt;
    reg         hp_seen;
    reg  [4*DW-1:0] next_data;
    reg  [4*DW-1:0] corr_data;
    wire [3:0]  offset_correction_enable = corr_enable[3:0];
    wire [3:0]  gain_correction_select   = corr_enable[7:4];
    wire [1:0]  fmt;
    wire        avg_on;
    wire [1:0]  avg_sel;
    wire        four_to_one;
    wire        fifo_in_ready;
    integer     i;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function [DW-1:0] sat;
        input signed [DW+24:0] v;
        reg signed [DW+24:0] maxv;
        reg signed [DW+24:0] minv;
        begin
            maxv = {{26{1'b0}}, {(DW-1){1'b1}}};
            minv = -maxv - 1;
            if (v > maxv)
                sat = maxv[DW-1:0];
            else if (v < minv)
                sat = minv[DW-1:0];
            else
                sat = v[DW-1:0];
        end
    endfunction

    function [DW-1:0] pick;
        input [4*DW-1:0] d0;
        input [4*DW-1:0] d1;
        input [4*DW-1:0] d2;
        input [1:0]      sel;
        input integer    ch;
        begin
            case (sel)
                2'h1:    pick = d1[ch*DW +: DW];
                2'h2:    pick = d2[ch*DW +: DW];
                default: pick = d0[ch*DW +: DW];
            endcase
        end
    endfunction

    // Buffer pointer width follows the depth; pointers wrap at a power of two, so the depth must be one
    function integer addr_bits;
        input integer depth;
        integer n;
        begin
            addr_bits = 0;
            for (n = depth - 1; n > 0; n = n >> 1)
                addr_bits = addr_bits + 1;
        end
    endfunction

    localparam FIFO_AW = addr_bits(FIFO_DEPTH);

    // ----------------------------------------------------------------
    // Register writes and reset to factory values
    // ----------------------------------------------------------------
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            interface_format_config <= `IF_FORMAT_RESET;
            power_ctrl              <= `POWER_CTRL_RESET;
            multiphase_delay_config <= `DELAY_CONFIG_RESET;
            corr_enable             <= `CORR_ENABLE_RESET;
            for (i = 0; i < 4; i = i + 1) begin
                channel_offset_coefficient[i] <= FACTORY_OFFSET[i*23 +: 23];
                channel_gain_coefficient[i]   <= FACTORY_GAIN[i*20 +: 20];
            end
        end else if (CE && REG_WR && !PIN_CONTROL) begin
            case (REG_ADDR)
                `IF_FORMAT_CONFIG_ADDR: interface_format_config <= REG_WDATA[7:0];
                `POWER_CTRL_ADDR:       power_ctrl <= REG_WDATA[7:0];
                `DELAY_CONFIG_ADDR:     multiphase_delay_config <= REG_WDATA[7:0];
                `CORR_ENABLE_ADDR:      corr_enable <= REG_WDATA[7:0];
                default: begin
                    if (REG_ADDR[6:2] == `OFFSET_BASE_ADDR >> 2)
                        channel_offset_coefficient[REG_ADDR[1:0]] <= REG_WDATA[22:0];
                    else if (REG_ADDR[6:2] == `GAIN_BASE_ADDR >> 2)
                        channel_gain_coefficient[REG_ADDR[1:0]] <= REG_WDATA[19:0];
                end
            endcase
        end
    end

    always @* begin
        REG_RDATA = 24'h000000;
        case (REG_ADDR)
            `IF_FORMAT_CONFIG_ADDR: REG_RDATA = {16'h0000, interface_format_config};
            `POWER_CTRL_ADDR:       REG_RDATA = {16'h0000, power_ctrl};
            `DELAY_CONFIG_ADDR:     REG_RDATA = {16'h0000, multiphase_delay_config};
            `CORR_ENABLE_ADDR:      REG_RDATA = {16'h0000, corr_enable};
            default: begin
                if (REG_ADDR[6:2] == `OFFSET_BASE_ADDR >> 2)
                    REG_RDATA = {1'b0, channel_offset_coefficient[REG_ADDR[1:0]]};
                else if (REG_ADDR[6:2] == `GAIN_BASE_ADDR >> 2)
                    REG_RDATA = {4'h0, channel_gain_coefficient[REG_ADDR[1:0]]};
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Power and antialias modes
    // ----------------------------------------------------------------
    wire pwr_sel = PIN_CONTROL ? POWER_MODE_STRAP_PIN : power_ctrl[`PWR_MODE_BIT];

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            POWER_MODE         <= `PMODE_LOW_POWER;
            ANTIALIAS_MODE_TWO <= 1'b0;
            hold_cnt           <= 32'h00000000;
            hp_seen            <= 1'b0;
            LOW_POWER_READY    <= 1'b0;
        end else if (CE) begin
            if (!POWER_DOWN_N)
                POWER_MODE <= `PMODE_POWER_DOWN;
            else if (!PIN_CONTROL && power_ctrl[`SLEEP_EN_BIT])
                POWER_MODE <= `PMODE_SLEEP;
            else if (pwr_sel)
                POWER_MODE <= `PMODE_HIGH_PERF;
            else
                POWER_MODE <= `PMODE_LOW_POWER;
            ANTIALIAS_MODE_TWO <= !PIN_CONTROL && power_ctrl[`ANTIALIAS_MODE_BIT_BIT];
            // Low power is only calibrated after a long high performance stint
            if (pwr_sel) begin
                if (hold_cnt < HOLD_CYCLES)
                    hold_cnt <= hold_cnt + 32'h00000001;
                else
                    hp_seen <= 1'b1;
            end else begin
                hold_cnt <= 32'h00000000;
                if (hp_seen)
                    LOW_POWER_READY <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Delay, correction, averaging
    // ----------------------------------------------------------------
    assign fmt         = PIN_CONTROL ? {OUTPUT_FORMAT_STRAP_HIGH, OUTPUT_FORMAT_STRAP_LOW}
                                     : interface_format_config[`FMT_LSB +: 2];
    assign avg_on      = (fmt == `FMT_AVERAGE);
    assign avg_sel     = interface_format_config[`AVG_SEL_LSB +: 2];
    assign four_to_one = PIN_CONTROL || (avg_sel == `AVG_SEL_FOUR);

    always @* begin : correct
        reg signed [DW+24:0] v;
        reg signed [DW+24:0] g;
        integer c;
        v = 0;
        g = 0;
        corr_data = {4*DW{1'b0}};
        for (c = 0; c < 4; c = c + 1) begin
            v = $signed(pick(SAMPLE_DATA, dly1, dly2,
                             multiphase_delay_config[c*2 +: 2], c));
            if (!PIN_CONTROL && offset_correction_enable[c])
                v = v + ($signed(channel_offset_coefficient[c]) <<< 1);
            if (!PIN_CONTROL && gain_correction_select[c]) begin
                g = $signed({1'b0, channel_gain_coefficient[c]}) - (1 <<< 19);
                v = v + ((v * g) >>> 20);
            end
            corr_data[c*DW +: DW] = sat(v);
        end
    end

    always @* begin : average
        reg signed [DW+1:0] s0;
        reg signed [DW+1:0] s1;
        reg signed [DW+1:0] q4;
        reg signed [DW+1:0] q0;
        reg signed [DW+1:0] q1;
        s0 = $signed(corr_data[0 +: DW]) + $signed(corr_data[DW +: DW]);
        s1 = $signed(corr_data[2*DW +: DW]) + $signed(corr_data[3*DW +: DW]);
        // Two guard bits so four full-scale codes cannot wrap before the shift
        q4 = (s0 + s1) >>> 2;
        q0 = s0 >>> 1;
        q1 = s1 >>> 1;
        next_data = corr_data;
        if (avg_on) begin
            next_data = {4*DW{1'b0}};
            if (four_to_one)
                next_data[0 +: DW] = q4[DW-1:0];
            else begin
                next_data[0 +: DW]  = q0[DW-1:0];
                next_data[DW +: DW] = q1[DW-1:0];
            end
        end
    end

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            dly1        <= {4*DW{1'b0}};
            dly2        <= {4*DW{1'b0}};
            LINE_ENABLE <= 4'hf;
        end else if (CE) begin
            if (SAMPLE_VALID) begin
                dly1 <= SAMPLE_DATA;
                dly2 <= dly1;
            end
            if (avg_on && four_to_one)
                LINE_ENABLE <= 4'h1;
            else if (avg_on)
                LINE_ENABLE <= 4'h3;
            else
                LINE_ENABLE <= 4'hf;
        end
    end

    // Samples arriving while full are dropped and flagged
    assign OVERRUN = SAMPLE_VALID & ~fifo_in_ready;

    sample_fifo #(
        .WIDTH (4*DW),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk       (CLK_SYS),
        .rst_n     (RST_N),
        .ce        (CE),
        .in_valid  (SAMPLE_VALID),
        .in_ready  (fifo_in_ready),
        .in_data   (next_data),
        .out_valid (OUT_VALID),
        .out_ready (OUT_READY),
        .out_data  (OUT_DATA)
    );
endmodule // chan_postprocess

// *** sim/chan_postprocess_assertions.sv ***
/*
 * Port-level checker for chan_postprocess, bound to the top module.
 * Assumes one clock CLK_SYS and synchronous active-low RST_N.
 */
`timescale 1ns/10ps
module chan_postprocess_assertions (
    // Clock and mode pins
    input wire logic        CLK_SYS,
    input wire logic        RST_N,
    input wire logic        CE,
    input wire logic        PIN_CONTROL,
    input wire logic        POWER_MODE_STRAP_PIN,
    input wire logic        OUTPUT_FORMAT_STRAP_LOW,
    input wire logic        OUTPUT_FORMAT_STRAP_HIGH,
    input wire logic        POWER_DOWN_N,
    // Register port
    input wire logic        REG_WR,
    input wire logic [6:0]  REG_ADDR,
    input wire logic [23:0] REG_RDATA,
    // Stream and status
    input wire logic        SAMPLE_VALID,
    input wire logic        OUT_VALID,
    input wire logic        OVERRUN,
    input wire logic [3:0]  LINE_ENABLE,
    input wire logic [1:0]  POWER_MODE,
    input wire logic        ANTIALIAS_MODE_TWO
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence s_pin_write;
        CE && PIN_CONTROL && REG_WR;
    endsequence
    sequence s_same_addr;
        REG_ADDR == $past(REG_ADDR);
    endsequence
    property p_pin_write_ignored;
        s_pin_write ##1 s_same_addr |-> REG_RDATA == $past(REG_RDATA);
    endproperty
    a_pin_write_ignored: assert property (p_pin_write_ignored)
        else $error("register changed by a write in pin mode");
    property p_power_down;
        CE && !POWER_DOWN_N |=> POWER_MODE == 2'h3;
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("power-down pin not honoured");
    property p_pin_power_select;
        CE && PIN_CONTROL && POWER_DOWN_N |=> POWER_MODE == {1'b0, $past(POWER_MODE_STRAP_PIN)};
    endproperty
    a_pin_power_select: assert property (p_pin_power_select)
        else $error("pin power mode does not follow strap");
    property p_reset_defaults;
        $rose(RST_N) |-> !ANTIALIAS_MODE_TWO && LINE_ENABLE == 4'hf && !OUT_VALID;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("wrong state after reset");
    property p_aa_reg_only;
        $rose(ANTIALIAS_MODE_TWO) |-> !$past(PIN_CONTROL);
    endproperty
    a_aa_reg_only: assert property (p_aa_reg_only)
        else $error("antialias mode two entered in pin mode");
    property p_pin_avg_lines;
        CE && PIN_CONTROL && OUTPUT_FORMAT_STRAP_LOW && OUTPUT_FORMAT_STRAP_HIGH
            |-> ##[1:2] LINE_ENABLE == 4'h1;
    endproperty
    a_pin_avg_lines: assert property (p_pin_avg_lines)
        else $error("pin averaging not on first line only");
    property p_sample_stored;
        CE && SAMPLE_VALID && !OVERRUN |=> OUT_VALID;
    endproperty
    a_sample_stored: assert property (p_sample_stored)
        else $error("accepted sample not offered");
    property p_overrun_full;
        OVERRUN |-> SAMPLE_VALID && OUT_VALID;
    endproperty
    a_overrun_full: assert property (p_overrun_full)
        else $error("overrun without a full buffer");
endmodule // chan_postprocess_assertions

bind chan_postprocess chan_postprocess_assertions u_chk (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(CE), .PIN_CONTROL(PIN_CONTROL),
    .POWER_MODE_STRAP_PIN(POWER_MODE_STRAP_PIN),
    .OUTPUT_FORMAT_STRAP_LOW(OUTPUT_FORMAT_STRAP_LOW),
    .OUTPUT_FORMAT_STRAP_HIGH(OUTPUT_FORMAT_STRAP_HIGH), .POWER_DOWN_N(POWER_DOWN_N),
    .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA),
    .SAMPLE_VALID(SAMPLE_VALID), .OUT_VALID(OUT_VALID), .OVERRUN(OVERRUN),
    .LINE_ENABLE(LINE_ENABLE), .POWER_MODE(POWER_MODE),
    .ANTIALIAS_MODE_TWO(ANTIALIAS_MODE_TWO));

// *** sim/host_sink.sv ***
/*
 * Host reading processed sample words; stalls on request.
 * Assumes the same clock and reset as the block.
 */
`timescale 1ns/10ps
module host_sink #(
    parameter W = 96
) (
    // Clock and control
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         stall,
    // Stream
    input  wire logic         valid,
    input  wire logic [W-1:0] data,
    output logic              ready
);
    logic [W-1:0] got[$];
    // Word taken only at an edge where both sides agree
    always @(posedge clk) begin
        if (!rst_n) begin
            ready <= 1'b0;
        end else begin
            if (valid && ready) begin
                got.push_back(data);
            end
            ready <= !stall;
        end
    end
endmodule // host_sink

// *** sim/testbench.sv ***
/*
 * Self-checking bench for chan_postprocess through its register port.
 * Assumes hdl/ on the include path and the host_sink partner.
 */
`timescale 1ns/10ps
`include "chan_post_regs.vh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module testbench;
    localparam HOLD = 20;
    logic        clk_sys = 1'b0, rst_n = 1'b0, pin_control = 1'b0, pwr_strap = 1'b0;
    logic        fmt_lo = 1'b0, fmt_hi = 1'b0, pd_n = 1'b1, reg_wr = 1'b0;
    logic        sample_valid = 1'b0, stall = 1'b0, out_valid, out_ready, overrun;
    logic        aa_two, lp_ready, ce = 1'b1;
    logic [6:0]  reg_addr = 7'h00;
    logic [23:0] reg_wdata = 24'h0, reg_rdata;
    logic [95:0] sample_data = 96'h0, out_data;
    logic [3:0]  line_enable;
    logic [1:0]  power_mode;
    int          n_fail = 0, checks_done = 0, i;

    always #12.5 clk_sys = ~clk_sys;

    chan_postprocess #(.HOLD_CYCLES(HOLD), .FACTORY_OFFSET({23'd4, 23'd3, 23'd2, 23'd1}),
        .FACTORY_GAIN({4{20'h80000}})) uut (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .CE(ce), .PIN_CONTROL(pin_control),
        .POWER_MODE_STRAP_PIN(pwr_strap), .OUTPUT_FORMAT_STRAP_LOW(fmt_lo),
        .OUTPUT_FORMAT_STRAP_HIGH(fmt_hi), .POWER_DOWN_N(pd_n), .REG_WR(reg_wr),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .SAMPLE_VALID(sample_valid), .SAMPLE_DATA(sample_data), .OUT_VALID(out_valid),
        .OUT_READY(out_ready), .OUT_DATA(out_data), .LINE_ENABLE(line_enable),
        .OVERRUN(overrun), .POWER_MODE(power_mode), .ANTIALIAS_MODE_TWO(aa_two),
        .LOW_POWER_READY(lp_ready));
    host_sink #(.W(96)) sink (.clk(clk_sys), .rst_n(rst_n), .stall(stall),
        .valid(out_valid), .data(out_data), .ready(out_ready));

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic do_reset;
        @(posedge clk_sys);
        rst_n <= 1'b0;
        tick(4);
        rst_n <= 1'b1;
    endtask
    task automatic wr(input [6:0] a, input [23:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input [6:0] a, input [23:0] e, input string nm);
        @(posedge clk_sys);
        reg_addr <= a;
        @(negedge clk_sys);
        `CHK(nm, e, reg_rdata)
    endtask
    task automatic send(input [95:0] d);
        @(posedge clk_sys);
        sample_valid <= 1'b1;
        sample_data <= d;
        @(posedge clk_sys);
        sample_valid <= 1'b0;
    endtask
    // Bounded wait for n words, checks the last one, then empties the queue
    task automatic out_chk(input int n, input [95:0] e, input string nm);
        int k;
        for (k = 0; k < 20 && sink.got.size() < n; k++) @(posedge clk_sys);
        `CHK(nm, e, sink.got[n-1])
        sink.got.delete();
    endtask
    function automatic [95:0] smp(input int k);
        smp = {24'(k*16+3), 24'(k*16+2), 24'(k*16+1), 24'(k*16)};
    endfunction
    task automatic complete_run;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        do_reset;
        `CHK("aa reset", 1'b0, aa_two)
        for (i = 0; i < 4; i++) begin
            rd(7'(`IF_FORMAT_CONFIG_ADDR+i), 24'h0, "config reset");
            rd(7'(`OFFSET_BASE_ADDR+i), 24'(i+1), "offset factory");
            rd(7'(`GAIN_BASE_ADDR+i), 24'h80000, "gain factory");
        end
        rd(7'h7f, 24'h0, "unmapped");
        wr(`OFFSET_BASE_ADDR, 24'h000123);
        rd(`OFFSET_BASE_ADDR, 24'h000123, "offset user");
        do_reset;
        rd(`OFFSET_BASE_ADDR, 24'h000001, "offset restored");
        $display("test registers done");
        wr(`DELAY_CONFIG_ADDR, 24'h000009);
        for (i = 1; i < 4; i++) send(smp(i));
        out_chk(3, {24'd51, 24'd50, 24'd17, 24'd32}, "delay");
        wr(`DELAY_CONFIG_ADDR, 24'h0);
        wr(7'h20, 24'd100);
        wr(7'h21, 24'h7ffffd);
        wr(7'h32, 24'hc0000);
        wr(7'h33, 24'h0);
        wr(`CORR_ENABLE_ADDR, 24'hc3);
        send({4{24'd400}});
        out_chk(1, {24'd200, 24'd500, 24'd394, 24'd600}, "correct");
        wr(7'h20, 24'h3fffff);
        send({4{24'h7ffff0}});
        out_chk(1, {24'h3ffff8, 24'h7fffff, 24'h7fffea, 24'h7fffff}, "sat");
        pin_control <= 1'b1;
        send({4{24'd400}});
        out_chk(1, {4{24'd400}}, "pin no correct");
        wr(`POWER_CTRL_ADDR, 24'h2);
        tick(2);
        `CHK("pin sleep", 2'h0, power_mode)
        pd_n <= 1'b0;
        tick(2);
        `CHK("pin down", 2'h3, power_mode)
        pd_n <= 1'b1;
        // No samples flowing when the strap moves
        pwr_strap <= 1'b1;
        tick(2);
        `CHK("pin hp", 2'h1, power_mode)
        pwr_strap <= 1'b0;
        fmt_lo <= 1'b1;
        fmt_hi <= 1'b1;
        send({24'h7ffffd, {3{24'h7fffff}}});
        out_chk(1, {72'h0, 24'h7ffffe}, "pin avg");
        `CHK("pin lines", 4'h1, line_enable)
        pin_control <= 1'b0;
        fmt_lo <= 1'b0;
        fmt_hi <= 1'b0;
        wr(`CORR_ENABLE_ADDR, 24'h0);
        $display("test pin mode done");
        wr(`IF_FORMAT_CONFIG_ADDR, 24'h3);
        send({24'hfffffc, 24'hfffffd, 24'hfffffe, 24'hffffff});
        out_chk(1, {72'h0, 24'hfffffd}, "avg four");
        `CHK("lines four", 4'h1, line_enable)
        wr(`IF_FORMAT_CONFIG_ADDR, 24'h7);
        send({24'hfffffc, 24'hffffff, 24'd13, 24'd10});
        out_chk(1, {48'h0, 24'hfffffd, 24'd11}, "avg two");
        `CHK("lines two", 4'h3, line_enable)
        wr(`IF_FORMAT_CONFIG_ADDR, 24'h4);
        send(smp(1));
        out_chk(1, smp(1), "no avg");
        `CHK("lines all", 4'hf, line_enable)
        wr(`IF_FORMAT_CONFIG_ADDR, 24'h0);
        $display("test averaging done");
        for (i = 0; i < 4; i++) begin
            wr(`POWER_CTRL_ADDR, 24'(i));
            tick(2);
            `CHK("reg power", 2'(i < 2 ? i : 2), power_mode)
        end
        pd_n <= 1'b0;
        tick(2);
        `CHK("reg down", 2'h3, power_mode)
        pd_n <= 1'b1;
        wr(`POWER_CTRL_ADDR, 24'h4);
        tick(2);
        `CHK("aa two", 1'b1, aa_two)
        pin_control <= 1'b1;
        tick(3);
        `CHK("aa pin", 1'b0, aa_two)
        pin_control <= 1'b0;
        // Short hold first, then the full hold the controller owes
        wr(`POWER_CTRL_ADDR, 24'h1);
        tick(5);
        wr(`POWER_CTRL_ADDR, 24'h0);
        tick(2);
        `CHK("lp early", 1'b0, lp_ready)
        wr(`POWER_CTRL_ADDR, 24'h1);
        tick(HOLD + 2);
        wr(`POWER_CTRL_ADDR, 24'h0);
        tick(2);
        `CHK("lp ready", 1'b1, lp_ready)
        // Clock enable low must freeze the registers
        ce <= 1'b0;
        wr(`POWER_CTRL_ADDR, 24'h2);
        rd(`POWER_CTRL_ADDR, 24'h0, "ce frozen");
        @(posedge clk_sys);
        ce <= 1'b1;
        $display("test power done");
        stall <= 1'b1;
        tick(2);
        sample_valid <= 1'b1;
        for (i = 0; i < 32; i++) begin
            sample_data <= smp(i);
            @(posedge clk_sys);
        end
        sample_data <= smp(32);
        @(negedge clk_sys);
        `CHK("overrun", 1'b1, overrun)
        @(posedge clk_sys);
        sample_valid <= 1'b0;
        stall <= 1'b0;
        for (i = 0; i < 80 && sink.got.size() < 32; i++) @(posedge clk_sys);
        tick(3);
        `CHK("drained", 32, sink.got.size())
        `CHK("first", smp(0), sink.got[0])
        `CHK("last", smp(31), sink.got[31])
        `CHK("empty", 1'b0, out_valid)
        $display("test buffer done");
        complete_run;
    end

    // Whole run is well under 1000 cycles
    initial begin
        #125000;
        n_fail++;
        complete_run;
    end
endmodule // testbench
